// File: src/gpx_top.sv
// Purpose: 16-pin gpio expander behind a serial two-wire target
// Assumes: scl and sda sampled by clk; pins are two-way, split in three signals
// Notes: direction bit 1 means input, as after reset all pins float
// Functional notes
// - sixteen pins, each individually input or driven output.
// - two 8-bit direction registers, bit per pin selects input or output.
// - two 8-bit polarity registers invert reported input data per bit.
// - input register captures pin levels; output register holds driven values.
// - every register is readable by the bus master.
// - interrupt output pulls low when any input pin changes state.
// - reset loads register defaults and returns the state machine to idle.
// - three select inputs pick one of eight bus addresses.
// - clock and data inputs are filtered against short glitches.
// - clock line only sensed; data line only pulled low.
// - two banks of eight; pin n maps to bit n of its bank registers.
// - address byte is 0100, select bits, then read/write bit.
// - first written byte is a command pointer, codes 0 to 7.
// - input registers read-only, live levels regardless of direction.
// - output register reads return stored value, inputs unaffected.
module gpx_top
    import gpx_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // serial bus
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // address select straps
    input wire logic addr_select_0,
    input wire logic addr_select_1,
    input wire logic addr_select_2,
    // gpio pins
    input wire gpx_pkg::gpx_word_t pin_in,
    output gpx_pkg::gpx_word_t pin_out,
    output gpx_pkg::gpx_word_t pin_oe,
    // interrupt, open drain
    output logic int_n_out,
    output logic int_n_oe
);
    import gpx_pkg::*;
    // ************************************************************
    // input conditioning
    // ************************************************************
    gpx_bus_t bus;
    logic scl_prev_q, sda_prev_q;
    logic [2:0] as1_q, as2_q;
    gpx_word_t ps1_q, ps2_q;
    gpx_filt #(.CYC(GPX_FILT_CYC)) u_scl (.clk(clk), .srst(srst), .raw(scl_in), .clean(bus.scl));
    gpx_filt #(.CYC(GPX_FILT_CYC)) u_sda (.clk(clk), .srst(srst), .raw(sda_in), .clean(bus.sda));
    always_ff @(posedge clk) begin
        as1_q <= {addr_select_2, addr_select_1, addr_select_0};
        as2_q <= as1_q;
        ps1_q <= pin_in;
        ps2_q <= ps1_q;
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_prev_q <= bus.scl;
            sda_prev_q <= bus.sda;
        end
    end
    wire scl_rise = bus.scl & ~scl_prev_q;
    wire scl_fall = ~bus.scl & scl_prev_q;
    wire start_c = bus.scl & scl_prev_q & sda_prev_q & ~bus.sda;
    wire stop_c = bus.scl & scl_prev_q & ~sda_prev_q & bus.sda;
    // ************************************************************
    // registers
    // ************************************************************
    gpx_word_t out_q, pol_q, dir_q;
    gpx_word_t in_view;
    assign in_view = ps2_q ^ pol_q;
    // ************************************************************
    // serial engine
    // ************************************************************
    gpx_state_t st_q;
    logic [2:0] bit_q;
    logic [7:0] sh_q;
    logic [2:0] cmd_q;
    logic ack_ph_q, nack_q, drv_q, rd_q, rel_q;
    logic wr_pulse, rd_load;
    logic [7:0] rd_byte;
    wire byte_done = scl_rise & (bit_q == 3'h7) & ~ack_ph_q;
    wire [7:0] sh_next = {sh_q[6:0], bus.sda};
    wire addr_hit = (sh_next[7:4] == GPX_ADDR_FIXED) & (sh_next[3:1] == as2_q);
    wire [7:0] reg_sel [8];
    assign reg_sel[0] = in_view.bank0;
    assign reg_sel[1] = in_view.bank1;
    assign reg_sel[2] = out_q.bank0;
    assign reg_sel[3] = out_q.bank1;
    assign reg_sel[4] = pol_q.bank0;
    assign reg_sel[5] = pol_q.bank1;
    assign reg_sel[6] = dir_q.bank0;
    assign reg_sel[7] = dir_q.bank1;
    assign rd_byte = reg_sel[cmd_q];
    always_ff @(posedge clk) begin
        if (srst) begin
            st_q <= GPX_IDLE;
            bit_q <= 3'h0;
            sh_q <= 8'h00;
            cmd_q <= GPX_RST_CMD;
            ack_ph_q <= 1'b0;
            nack_q <= 1'b0;
            drv_q <= 1'b0;
            rd_q <= 1'b0;
            rel_q <= 1'b0;
        end else if (start_c) begin
            st_q <= GPX_ADDR;
            bit_q <= 3'h0;
            ack_ph_q <= 1'b0;
            drv_q <= 1'b0;
            rel_q <= 1'b0;
        end else if (stop_c) begin
            st_q <= GPX_IDLE;
            drv_q <= 1'b0;
            ack_ph_q <= 1'b0;
            rel_q <= 1'b0;
        end else begin
            if (scl_rise & ~ack_ph_q) begin
                sh_q <= sh_next;
                bit_q <= bit_q + 3'h1;
            end
            if (scl_rise & ack_ph_q) begin
                nack_q <= bus.sda;
            end
            if (byte_done) begin
                ack_ph_q <= 1'b1;
                unique case (st_q)
                    GPX_ADDR: begin
                        rd_q <= sh_next[0];
                        if (!addr_hit) begin
                            st_q <= GPX_IDLE;
                            ack_ph_q <= 1'b0;
                        end
                    end
                    GPX_CMD: cmd_q <= sh_next[2:0];
                    GPX_WDAT: cmd_q <= {cmd_q[2:1], ~cmd_q[0]};
                    GPX_RDAT: ;
                    GPX_IDLE: ack_ph_q <= 1'b0;
                endcase
            end
            if (scl_fall) begin
                if (ack_ph_q & ~drv_q & st_q != GPX_RDAT) begin
                    drv_q <= 1'b1; // ack by pulling low
                end else if (ack_ph_q & drv_q & st_q != GPX_RDAT) begin
                    ack_ph_q <= 1'b0;
                    bit_q <= 3'h0;
                    unique case (st_q)
                        GPX_ADDR: st_q <= rd_q ? GPX_RDAT : GPX_CMD;
                        GPX_CMD: st_q <= GPX_WDAT;
                        default: st_q <= st_q;
                    endcase
                    drv_q <= (st_q == GPX_ADDR & rd_q) ? ~rd_byte[7] : 1'b0;
                    sh_q <= rd_byte;
                end else if (st_q == GPX_RDAT & ack_ph_q & ~rel_q) begin
                    // let go of sda so the master can ack or nack
                    drv_q <= 1'b0;
                    rel_q <= 1'b1;
                end else if (st_q == GPX_RDAT & ack_ph_q) begin
                    // master acks a read byte; nack means stop sending
                    rel_q <= 1'b0;
                    ack_ph_q <= 1'b0;
                    bit_q <= 3'h0;
                    cmd_q <= {cmd_q[2:1], ~cmd_q[0]};
                    sh_q <= reg_sel[{cmd_q[2:1], ~cmd_q[0]}];
                    drv_q <= ~nack_q & ~reg_sel[{cmd_q[2:1], ~cmd_q[0]}][7];
                    if (nack_q) st_q <= GPX_IDLE;
                end else if (st_q == GPX_RDAT & ~ack_ph_q) begin
                    drv_q <= ~sh_q[7];
                end
            end
        end
    end
    assign wr_pulse = byte_done & (st_q == GPX_WDAT);
    assign rd_load = scl_fall & (st_q == GPX_RDAT | (st_q == GPX_ADDR & rd_q)) & ack_ph_q;
    // ************************************************************
    // register file
    // ************************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            out_q <= {GPX_RST_OUT, GPX_RST_OUT};
            pol_q <= {GPX_RST_POL, GPX_RST_POL};
            dir_q <= {GPX_RST_DIR, GPX_RST_DIR};
        end else if (wr_pulse & ~start_c & ~stop_c) begin
            unique case (cmd_q)
                GPX_CMD_OUT0: out_q.bank0 <= sh_next;
                GPX_CMD_OUT1: out_q.bank1 <= sh_next;
                GPX_CMD_POL0: pol_q.bank0 <= sh_next;
                GPX_CMD_POL1: pol_q.bank1 <= sh_next;
                GPX_CMD_DIR0: dir_q.bank0 <= sh_next;
                GPX_CMD_DIR1: dir_q.bank1 <= sh_next;
                default: ;
            endcase
        end
    end
    // ************************************************************
    // pins and interrupt
    // ************************************************************
    // snapshot is the last level reported; change is judged against it
    gpx_word_t snap_q;
    wire rd0 = rd_load & (cmd_q == GPX_CMD_IN0);
    wire rd1 = rd_load & (cmd_q == GPX_CMD_IN1);
    wire [15:0] diff = (ps2_q ^ snap_q) & dir_q;
    always_ff @(posedge clk) begin
        if (srst) begin
            snap_q <= 16'h0000;
            pin_out <= 16'h0000;
            pin_oe <= 16'h0000;
            int_n_oe <= 1'b0;
            sda_oe <= 1'b0;
            sda_out <= 1'b0;
            int_n_out <= 1'b0;
        end else begin
            if (rd0) snap_q.bank0 <= ps2_q.bank0;
            if (rd1) snap_q.bank1 <= ps2_q.bank1;
            pin_out <= out_q;
            pin_oe <= ~dir_q;
            int_n_oe <= |diff;
            sda_oe <= drv_q & ~start_c & ~stop_c;
            sda_out <= 1'b0;
            int_n_out <= 1'b0;
        end
    end
endmodule

// File: src/gpx_pkg.sv
// Purpose: shared constants and types for the serial gpio expander
// Assumes: 20 MHz system clock, serial bus up to 400 kHz
// Notes: command codes select one of eight 8-bit registers
package gpx_pkg;
    // ************************************************************
    // address and commands
    // ************************************************************
    localparam logic [3:0] GPX_ADDR_FIXED = 4'h4;
    localparam logic [2:0] GPX_CMD_IN0 = 3'h0;
    localparam logic [2:0] GPX_CMD_IN1 = 3'h1;
    localparam logic [2:0] GPX_CMD_OUT0 = 3'h2;
    localparam logic [2:0] GPX_CMD_OUT1 = 3'h3;
    localparam logic [2:0] GPX_CMD_POL0 = 3'h4;
    localparam logic [2:0] GPX_CMD_POL1 = 3'h5;
    localparam logic [2:0] GPX_CMD_DIR0 = 3'h6;
    localparam logic [2:0] GPX_CMD_DIR1 = 3'h7;
    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] GPX_RST_OUT = 8'hff;
    localparam logic [7:0] GPX_RST_POL = 8'h00;
    localparam logic [7:0] GPX_RST_DIR = 8'hff;
    localparam logic [2:0] GPX_RST_CMD = 3'h0;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int GPX_CLK_HZ = 20000000;
    localparam int GPX_SPIKE_NS = 50;
    localparam int GPX_FILT_CYC = (GPX_SPIKE_NS * (GPX_CLK_HZ / 1000000) + 999) / 1000 + 1;
    // ************************************************************
    // types
    // ************************************************************
    typedef struct packed {
        logic [7:0] bank1;
        logic [7:0] bank0;
    } gpx_word_t;
    typedef struct packed {
        logic scl;
        logic sda;
    } gpx_bus_t;
    typedef enum logic [4:0] {
        GPX_IDLE = 5'b00001,
        GPX_ADDR = 5'b00010,
        GPX_CMD = 5'b00100,
        GPX_WDAT = 5'b01000,
        GPX_RDAT = 5'b10000
    } gpx_state_t;
endpackage

// File: src/gpx_filt.sv
// Purpose: two-flop sync plus glitch filter for one serial line
// Assumes: line idles high
// Notes: output changes only after the input holds steady
module gpx_filt #(
    parameter int CYC = 3
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // line
    input wire logic raw,
    output logic clean
);
    logic s1_q, s2_q;
    logic [3:0] cnt_q;
    always_ff @(posedge clk) begin
        if (srst) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            cnt_q <= 4'h0;
            clean <= 1'b1;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
            if (s2_q == clean) begin
                cnt_q <= 4'h0;
            end else if (cnt_q == 4'(CYC - 1)) begin
                cnt_q <= 4'h0;
                clean <= s2_q;
            end else begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end
endmodule

// File: tb/gpx_top_properties.sv
// Purpose: port checks for the serial gpio expander
// Assumes: one clock domain, srst synchronous active high
// Notes: bus framing is judged by the bench
module gpx_top_chk
    import gpx_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // serial bus
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    // pins and interrupt
    input wire gpx_pkg::gpx_word_t pin_in,
    input wire gpx_pkg::gpx_word_t pin_out,
    input wire gpx_pkg::gpx_word_t pin_oe,
    input wire logic int_n_out,
    input wire logic int_n_oe
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (srst);
    // ****************
    // helpers
    // ****************
    // idle limit of 12 leaves room for filter and sync lag after a stop
    logic [4:0] idle_q;
    logic [3:0] quiet_q;
    gpx_word_t pin_q;
    always_ff @(posedge clk) begin
        idle_q <= (srst || !(scl_in && sda_in)) ? 5'h0 : idle_q + {4'h0, idle_q != 5'h1f};
        quiet_q <= (srst || pin_in != pin_q) ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hf};
        pin_q <= pin_in;
    end
    sequence ack_hold;
        sda_oe [*4];
    endsequence
    // ****************
    // properties
    // ****************
    chk_sda_drain: assert property (sda_out == 1'b0)
        else $error("sda driven high");
    chk_int_drain: assert property (int_n_out == 1'b0)
        else $error("interrupt driven high");
    chk_reset_load: assert property (disable iff (1'b0) srst |=> !sda_oe && !int_n_oe && pin_oe == 16'h0)
        else $error("outputs not cleared by reset");
    chk_out_default: assert property ($fell(srst) |-> ##[1:3] pin_out == {2{GPX_RST_OUT}})
        else $error("output default not loaded");
    chk_idle_out: assert property (idle_q > 5'hb |-> $stable(pin_out))
        else $error("output moved on idle bus");
    chk_idle_dir: assert property (idle_q > 5'hb |-> $stable(pin_oe))
        else $error("direction moved on idle bus");
    chk_idle_free: assert property (idle_q > 5'hb |-> !sda_oe)
        else $error("sda pulled on idle bus");
    chk_ack_hold: assert property ($rose(sda_oe) |-> ack_hold)
        else $error("sda pull too short");
    chk_int_cause: assert property ($rose(int_n_oe) |-> quiet_q < 4'h8)
        else $error("interrupt without pin change");
endmodule
bind gpx_top gpx_top_chk u_chk (.clk(clk), .srst(srst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .int_n_out(int_n_out),
    .int_n_oe(int_n_oe));

// File: tb/gpx_bus_master.sv
// Purpose: behavioural two-wire bus master
// Assumes: sda has a pull-up; scl stands high between frames
// Notes: 400 ns bit period; sda read just before scl falls
module gpx_bus_master (
    // bus lines
    output logic scl,
    output logic sda_rel,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************
    // frame tasks
    // ****************
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end
    task automatic start;
        #100 sda_rel = 1'b1;
        #200 scl = 1'b1;
        #100 sda_rel = 1'b0;
        #100 scl = 1'b0;
    endtask
    task automatic stop;
        #100 sda_rel = 1'b0;
        #100 scl = 1'b1;
        #100 sda_rel = 1'b1;
        #100;
    endtask
    // late sample: the target answers through its filter, well after scl falls
    // long low phase: the target lets go of sda some 300 ns after scl falls
    task automatic xbit(input logic b, output logic r);
        #100 sda_rel = b;
        #200 scl = 1'b1;
        #90 r = sda;
        #10 scl = 1'b0;
    endtask
    task automatic xbyte(input logic [7:0] d, input logic ack, output logic [7:0] q, output logic nak);
        for (int i = 7; i >= 0; i--) begin
            xbit(d[i], q[i]);
        end
        xbit(ack, nak);
    endtask
endmodule

// File: tb/testbench.sv
// Purpose: self-checking bench for the serial gpio expander
// Assumes: master model makes scl; sda and pin levels resolved here
// Notes: each scenario judges its own frames
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import gpx_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [2:0] strap = 3'h5;
    logic [15:0] ext = 16'h0;
    gpx_word_t pin_lvl, pin_out, pin_oe;
    logic sda_out, sda_oe, int_n_out, int_n_oe, scl, sda_rel, nk;
    logic [7:0] q0, q1;
    int fails = 0;
    int n_compared = 0;
    // pull-up on sda; a pin shows the driven value where enabled
    wire sda = sda_rel & ~sda_oe;
    assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext);
    always #25 clk = ~clk;
    gpx_top uut (.clk(clk), .srst(srst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .addr_select_0(strap[0]), .addr_select_1(strap[1]), .addr_select_2(strap[2]), .pin_in(pin_lvl),
        .pin_out(pin_out), .pin_oe(pin_oe), .int_n_out(int_n_out), .int_n_oe(int_n_oe));
    gpx_bus_master m (.scl(scl), .sda_rel(sda_rel), .sda(sda));
    // ****************
    // shared tasks
    // ****************
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // always a register pair: pointer moves to the partner register
    task automatic wr(input logic [2:0] cmd, input logic [7:0] d0, input logic [7:0] d1);
        m.start;
        m.xbyte({GPX_ADDR_FIXED, strap, 1'b0}, 1'b1, q0, nk);
        chk({15'h0, nk}, 16'h0);
        m.xbyte({5'h0, cmd}, 1'b1, q0, nk);
        m.xbyte(d0, 1'b1, q0, nk);
        m.xbyte(d1, 1'b1, q0, nk);
        m.stop;
    endtask
    task automatic rd(input logic [2:0] cmd, input logic [15:0] exp);
        m.start;
        m.xbyte({GPX_ADDR_FIXED, strap, 1'b0}, 1'b1, q0, nk);
        m.xbyte({5'h0, cmd}, 1'b1, q0, nk);
        m.start;
        m.xbyte({GPX_ADDR_FIXED, strap, 1'b1}, 1'b1, q0, nk);
        m.xbyte(8'hff, 1'b0, q0, nk);
        m.xbyte(8'hff, 1'b1, q1, nk);
        m.stop;
        chk({q1, q0}, exp);
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic t_reset;
        chk(pin_oe, 16'h0);
        chk(pin_out, {2{GPX_RST_OUT}});
        chk({15'h0, int_n_oe}, 16'h0);
        rd(GPX_CMD_DIR0, {2{GPX_RST_DIR}});
        rd(GPX_CMD_POL0, {2{GPX_RST_POL}});
    endtask
    task automatic t_addr;
        for (int a = 0; a < 8; a++) begin
            strap = 3'(a);
            #200;
            m.start;
            m.xbyte({GPX_ADDR_FIXED, 3'(a ^ 1), 1'b0}, 1'b1, q0, nk);
            chk({15'h0, nk}, 16'h1);
            m.stop;
            m.start;
            m.xbyte({GPX_ADDR_FIXED, 3'(a), 1'b0}, 1'b1, q0, nk);
            chk({15'h0, nk}, 16'h0);
            m.stop;
        end
    endtask
    task automatic t_write;
        wr(GPX_CMD_DIR0, 8'h00, 8'hf0);
        chk(pin_oe, 16'h0fff);
        wr(GPX_CMD_OUT0, 8'ha5, 8'h3c);
        chk(pin_out, 16'h3ca5);
        rd(GPX_CMD_OUT0, 16'h3ca5);
        rd(GPX_CMD_DIR0, 16'hf000);
    endtask
    // output pins read back through the input register, upper bank-1 pins are inputs
    task automatic t_input;
        wr(GPX_CMD_POL0, 8'hff, 8'h0f);
        ext = 16'h9000;
        wr(GPX_CMD_IN0, 8'h55, 8'h55);
        rd(GPX_CMD_IN0, 16'h935a);
        rd(GPX_CMD_POL0, 16'h0fff);
    endtask
    task automatic t_irq;
        chk({15'h0, int_n_oe}, 16'h0);
        ext = 16'h1000;
        #400;
        chk({15'h0, int_n_oe}, 16'h1);
        ext = 16'h9000;
        #400;
        chk({15'h0, int_n_oe}, 16'h0);
        ext = 16'h1000;
        #400;
        chk({15'h0, int_n_oe}, 16'h1);
        rd(GPX_CMD_IN0, 16'h135a);
        chk({15'h0, int_n_oe}, 16'h0);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        #1 srst = 1'b0;
        repeat (5) @(posedge clk);
        #1;
        t_reset;
        t_addr;
        t_write;
        t_input;
        t_irq;
        tally_and_finish;
    end
    // whole run needs about 270 us
    initial begin
        #1000000;
        fails++;
        tally_and_finish;
    end
endmodule
